// ### rtl/sph_defs.vh
// Byte codes, packet layout and timing constants for the packet handshake sequencer
`ifndef SPH_DEFS_VH
`define SPH_DEFS_VH
`define SPH_STX            8'h02
`define SPH_ETX            8'h03
`define SPH_EOT            8'h04
`define SPH_ENQ            8'h05
`define SPH_ACK            8'h06
`define SPH_SPACE          8'h20
`define SPH_CHR_0          8'h30
`define SPH_CHR_2          8'h32
`define SPH_CHR_A          8'h41
`define SPH_CHR_B          8'h42
`define SPH_CHR_D          8'h44
`define SPH_CMD_LEN        8'h04
`define SPH_TIMEOUT_MS     2000
`define SPH_CLK_KHZ        20000
`define SPH_TIMEOUT_CYC    (`SPH_TIMEOUT_MS * `SPH_CLK_KHZ)
`define SPH_DATA_MAX       8
`endif

// ### rtl/sph_fifo.v
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module sph_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clk_sys,
    input  wire             rst_b,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
        if (!rst_b) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule // sph_fifo

// ### rtl/sph_seq.v
// Handshake sequencer for the ASCII text-packet command link
`timescale 1ns/1ns
`include "sph_defs.vh"

// Overview of operation
// - Enquiry is answered with lone acknowledge 0x06, then hold for a packet.
// - No packet within 2 seconds: timeout, send failure reply.
// - Good write packet: send success reply 02 30 32 41 30 32 44 03.
// - Bad, unexecutable or timed-out packet: send failure reply ...41 32 32 42 03.
// - Control codes travel as lone bytes, never framed by 0x02/0x03.
// - Command fields shorter than four characters are padded with 0x20.
// - Acceptable read packet is answered with success reply before any data.
// - Client acknowledge in a read: send framed data packet, command beginning 0x44.
// - Checksum is zero minus sum of length through data, sent as two hex chars.
// - Length field counts command plus data characters as two hex chars.
// - Bytes are 8N1 on the link; serialising is outside this block.
// - Any byte received in hold restarts the packet-wait timeout.
module sph_seq #(
    parameter         DATA_MAX    = `SPH_DATA_MAX,
    parameter [31:0]  TIMEOUT_CYC = `SPH_TIMEOUT_CYC
) (
    input  wire                  clk_sys,
    input  wire                  rst_b,
    input  wire [7:0]            rx_data,
    input  wire                  rx_valid,
    output reg  [7:0]            tx_data,
    output reg                   tx_valid,
    input  wire                  tx_ready,
    output reg  [31:0]           cmd_word,
    output reg  [8*DATA_MAX-1:0] cmd_arg,
    output reg  [7:0]            cmd_arg_len,
    output reg                   cmd_is_read,
    output reg                   cmd_strobe,
    input  wire                  exec_done,
    input  wire                  exec_ok,
    input  wire [8*DATA_MAX-1:0] read_data,
    input  wire [7:0]            read_len,
    output reg                   hold_active,
    output reg                   timeout_flag
);
    localparam [3:0] ST_IDLE = 4'h0, ST_HOLD = 4'h1, ST_LEN0 = 4'h2, ST_LEN1 = 4'h3,
                     ST_BODY = 4'h4, ST_CK0 = 4'h5, ST_CK1 = 4'h6, ST_ETX = 4'h7,
                     ST_EXEC = 4'h8, ST_SEND = 4'h9, ST_RDACK = 4'hA;
    localparam [1:0] PK_OK = 2'h0, PK_FAIL = 2'h1, PK_DATA = 2'h2, PK_ACK = 2'h3;

    reg  [3:0]  state;
    reg  [31:0] tmo_cnt;
    reg  [7:0]  len;
    reg  [7:0]  idx;
    reg  [7:0]  sum;
    reg  [3:0]  ck_hi;
    reg         bad;
    reg  [1:0]  pk_kind;
    reg  [7:0]  tx_idx;
    reg         tx_busy;
    reg         read_pend;
    wire [7:0]  q_data;
    wire        q_valid;
    wire        q_ready;
    reg  [7:0]  f_data;
    reg         f_valid;
    wire        f_ready;
    reg  [7:0]  pk_len;
    reg  [7:0]  pk_sum;

    // Hex nibble <-> ASCII
    function [3:0] hex_val;
        input [7:0] c;
        begin
            if (c >= 8'h30 && c <= 8'h39) hex_val = c[3:0];
            else if (c >= 8'h41 && c <= 8'h46) hex_val = c[3:0] + 4'h9;
            else hex_val = 4'h0;
        end
    endfunction
    function hex_ok;
        input [7:0] c;
        begin
            hex_ok = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
        end
    endfunction
    function [7:0] hex_chr;
        input [3:0] n;
        begin
            hex_chr = (n < 4'hA) ? {4'h3, n} : (8'h37 + {4'h0, n});
        end
    endfunction

    // Reply packet image: success, failure, data reply or lone acknowledge
    function [7:0] pk_byte;
        input [1:0] kind;
        input [7:0] i;
        input [7:0] n;
        input [7:0] cks;
        input [8*DATA_MAX-1:0] d;
        reg   [7:0] last;
        begin
            last = n + 8'h04;
            pk_byte = 8'h00;
            if (kind == PK_ACK) pk_byte = `SPH_ACK;
            else if (i == 8'h00) pk_byte = `SPH_STX;
            else if (i == 8'h01) pk_byte = hex_chr(n[7:4]);
            else if (i == 8'h02) pk_byte = hex_chr(n[3:0]);
            else if (i == 8'h03) pk_byte = (kind == PK_DATA) ? `SPH_CHR_D : `SPH_CHR_A;
            else if (i == 8'h04) pk_byte = (kind == PK_FAIL) ? `SPH_CHR_2 : `SPH_CHR_0;
            else if (i == last - 8'h01) pk_byte = hex_chr(cks[7:4]);
            else if (i == last) pk_byte = hex_chr(cks[3:0]);
            else if (i == last + 8'h01) pk_byte = `SPH_ETX;
            else pk_byte = d[8*DATA_MAX-1 - 8*(i-8'h05) -: 8];
        end
    endfunction

    function [7:0] pk_cks;
        input [1:0] kind;
        input [7:0] n;
        input [8*DATA_MAX-1:0] d;
        integer k;
        reg [7:0] s;
        begin
            s = 8'h00 - hex_chr(n[7:4]) - hex_chr(n[3:0]);
            s = s - ((kind == PK_DATA) ? `SPH_CHR_D : `SPH_CHR_A);
            s = s - ((kind == PK_FAIL) ? `SPH_CHR_2 : `SPH_CHR_0);
            for (k = 0; k < DATA_MAX; k = k + 1) begin
                if (kind == PK_DATA && k + 2 < n) s = s - d[8*DATA_MAX-1-8*k -: 8];
            end
            pk_cks = s;
        end
    endfunction

    always @* begin
        pk_len = (pk_kind == PK_DATA) ? read_len + 8'h02 : 8'h02;
        pk_sum = pk_cks(pk_kind, pk_len, read_data);
        f_data = pk_byte(pk_kind, tx_idx, pk_len, pk_sum, read_data);
        f_valid = tx_busy;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outgoing bytes are queued so a slow UART back-pressures the sequencer
    sph_fifo #(.WIDTH(8), .DEPTH(4), .AW(2)) u_txq (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .in_data   (f_data),
        .in_valid  (f_valid),
        .in_ready  (f_ready),
        .out_data  (q_data),
        .out_valid (q_valid),
        .out_ready (q_ready)
    );
    assign q_ready = ~tx_valid | tx_ready;

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            tx_data  <= 8'h00;
            tx_valid <= 1'b0;
        end else if (q_ready) begin
            // One whole byte per handshake; the UART adds start and stop bits
            tx_data  <= q_data;
            tx_valid <= q_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            state        <= ST_IDLE;
            tmo_cnt      <= 32'h0;
            len          <= 8'h00;
            idx          <= 8'h00;
            sum          <= 8'h00;
            ck_hi        <= 4'h0;
            bad          <= 1'b0;
            pk_kind      <= PK_ACK;
            tx_idx       <= 8'h00;
            tx_busy      <= 1'b0;
            read_pend    <= 1'b0;
            cmd_word     <= 32'h0;
            cmd_arg      <= {8*DATA_MAX{1'b0}};
            cmd_arg_len  <= 8'h00;
            cmd_is_read  <= 1'b0;
            cmd_strobe   <= 1'b0;
            hold_active  <= 1'b0;
            timeout_flag <= 1'b0;
        end else begin
            cmd_strobe  <= 1'b0;
            hold_active <= (state == ST_HOLD);
            if (tx_busy && f_ready) begin
                if (pk_kind == PK_ACK || tx_idx == pk_len + 8'h05) begin
                    tx_busy <= 1'b0;
                    tx_idx  <= 8'h00;
                end else begin
                    tx_idx <= tx_idx + 8'h01;
                end
            end
            case (state)
            ST_IDLE: begin
                if (rx_valid && rx_data == `SPH_ENQ) begin
                    pk_kind <= PK_ACK;
                    tx_busy <= 1'b1;
                    tmo_cnt <= 32'h0;
                    timeout_flag <= 1'b0;
                    state   <= ST_HOLD;
                end
            end
            ST_HOLD, ST_LEN0, ST_LEN1, ST_BODY, ST_CK0, ST_CK1, ST_ETX: begin
                if (rx_valid) begin
                    tmo_cnt <= 32'h0;
                end else if (!tx_busy) begin
                    tmo_cnt <= tmo_cnt + 32'h1;
                end
                if (rx_valid && rx_data == `SPH_EOT) begin
                    state <= ST_IDLE;
                end else if (!rx_valid && !tx_busy && tmo_cnt >= TIMEOUT_CYC - 32'h1) begin
                    timeout_flag <= 1'b1;
                    pk_kind <= PK_FAIL;
                    tx_busy <= 1'b1;
                    state   <= ST_SEND;
                end else if (rx_valid) begin
                    case (state)
                    ST_HOLD: if (rx_data == `SPH_STX) begin
                        bad <= 1'b0;
                        sum <= 8'h00;
                        cmd_word <= {4{`SPH_SPACE}};
                        cmd_arg  <= {8*DATA_MAX{1'b0}};
                        state <= ST_LEN0;
                    end
                    ST_LEN0: begin
                        len <= {hex_val(rx_data), 4'h0};
                        bad <= ~hex_ok(rx_data);
                        sum <= sum - rx_data;
                        state <= ST_LEN1;
                    end
                    ST_LEN1: begin
                        len <= {len[7:4], hex_val(rx_data)};
                        bad <= bad | ~hex_ok(rx_data);
                        sum <= sum - rx_data;
                        idx <= 8'h00;
                        state <= ({len[7:4], hex_val(rx_data)} == 8'h00) ? ST_CK0 : ST_BODY;
                    end
                    ST_BODY: begin
                        sum <= sum - rx_data;
                        if (idx < `SPH_CMD_LEN)
                            cmd_word[31 - 8*idx[1:0] -: 8] <= rx_data;
                        else if (idx - `SPH_CMD_LEN < DATA_MAX)
                            cmd_arg[8*DATA_MAX-1 - 8*(idx-`SPH_CMD_LEN) -: 8] <= rx_data;
                        else
                            bad <= 1'b1;
                        idx <= idx + 8'h01;
                        if (idx + 8'h01 == len) state <= ST_CK0;
                    end
                    ST_CK0: begin
                        ck_hi <= hex_val(rx_data);
                        bad <= bad | ~hex_ok(rx_data);
                        state <= ST_CK1;
                    end
                    ST_CK1: begin
                        bad <= bad | ~hex_ok(rx_data) | ({ck_hi, hex_val(rx_data)} != sum);
                        state <= ST_ETX;
                    end
                    ST_ETX: begin
                        if (rx_data != `SPH_ETX || bad || len < `SPH_CMD_LEN) begin
                            pk_kind <= PK_FAIL;
                            tx_busy <= 1'b1;
                            state   <= ST_SEND;
                        end else begin
                            cmd_arg_len <= len - `SPH_CMD_LEN;
                            cmd_is_read <= (len == `SPH_CMD_LEN);
                            cmd_strobe  <= 1'b1;
                            state       <= ST_EXEC;
                        end
                    end
                    default: state <= ST_HOLD;
                    endcase
                end
            end
            ST_EXEC: if (exec_done) begin
                pk_kind   <= exec_ok ? PK_OK : PK_FAIL;
                read_pend <= exec_ok & cmd_is_read;
                tx_busy   <= 1'b1;
                state     <= ST_SEND;
            end
            ST_SEND: if (!tx_busy) begin
                tmo_cnt <= 32'h0;
                // Failure drops the hold; client must restart with an enquiry
                state <= (pk_kind == PK_FAIL) ? ST_IDLE :
                         read_pend ? ST_RDACK : ST_HOLD;
            end
            ST_RDACK: if (rx_valid) begin
                if (rx_data == `SPH_ACK) begin
                    pk_kind   <= PK_DATA;
                    read_pend <= 1'b0;
                    tx_busy   <= 1'b1;
                    state     <= ST_SEND;
                end else if (rx_data == `SPH_EOT) begin
                    read_pend <= 1'b0;
                    state     <= ST_IDLE;
                end
            end
            default: state <= ST_IDLE;
            endcase
        end
    end
endmodule // sph_seq

// ### verification/sph_seq_chk.sv
// Port checker for the packet handshake sequencer
`timescale 1ns/1ns
`include "sph_defs.vh"
module sph_seq_chk #(
    parameter        DATA_MAX    = 8,
    parameter [31:0] TIMEOUT_CYC = 200
) (
    input wire                  clk_sys,
    input wire                  rst_b,
    input wire [7:0]            rx_data,
    input wire                  rx_valid,
    input wire [7:0]            tx_data,
    input wire                  tx_valid,
    input wire                  tx_ready,
    input wire [31:0]           cmd_word,
    input wire [8*DATA_MAX-1:0] cmd_arg,
    input wire [7:0]            cmd_arg_len,
    input wire                  cmd_is_read,
    input wire                  cmd_strobe,
    input wire                  exec_done,
    input wire                  exec_ok,
    input wire [8*DATA_MAX-1:0] read_data,
    input wire [7:0]            read_len,
    input wire                  hold_active,
    input wire                  timeout_flag
);
    // Cycles since the last received byte, since any byte restarts the wait
    reg [31:0] quiet;
    reg [1:0]  etx_d;
    always @(posedge clk_sys) begin
        if (!rst_b || rx_valid) quiet <= 32'h0;
        else quiet <= quiet + 32'h1;
        if (!rst_b) etx_d <= 2'h0;
        else etx_d <= {etx_d[0], rx_valid && rx_data == `SPH_ETX};
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_enq_ack: assert property (
        rx_valid && rx_data == `SPH_ENQ && !hold_active && !tx_valid
        |-> ##3 tx_valid && tx_data == `SPH_ACK) else $error("enquiry not acknowledged");
    a_enq_hold: assert property (
        rx_valid && rx_data == `SPH_ENQ && !hold_active && !tx_valid |-> ##[1:3] hold_active)
        else $error("no hold after enquiry");
    a_tx_stands: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("tx byte dropped");
    a_strobe_once: assert property (
        cmd_strobe |=> !cmd_strobe) else $error("strobe longer than one cycle");
    a_strobe_etx: assert property (
        cmd_strobe |-> etx_d != 2'h0) else $error("strobe without end of text");
    a_reply_exec: assert property (
        exec_done |-> ##[1:8] tx_valid && tx_data == `SPH_STX) else $error("no reply");
    a_timeout_reply: assert property (
        $rose(timeout_flag) |-> ##[0:8] tx_valid && tx_data == `SPH_STX)
        else $error("timeout without failure reply");
    a_timeout_span: assert property (
        $rose(timeout_flag) |-> quiet + 32'h2 >= TIMEOUT_CYC && quiet <= TIMEOUT_CYC + 32'hC)
        else $error("timeout at wrong count");
    a_eot_idle: assert property (
        rx_valid && rx_data == `SPH_EOT && hold_active |-> ##[1:3] !hold_active)
        else $error("end of transmission kept hold");
endmodule // sph_seq_chk
bind sph_seq sph_seq_chk #(.DATA_MAX(DATA_MAX), .TIMEOUT_CYC(TIMEOUT_CYC)) i_sph_seq_chk (
    .clk_sys(clk_sys), .rst_b(rst_b), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .cmd_word(cmd_word),
    .cmd_arg(cmd_arg), .cmd_arg_len(cmd_arg_len), .cmd_is_read(cmd_is_read),
    .cmd_strobe(cmd_strobe), .exec_done(exec_done), .exec_ok(exec_ok),
    .read_data(read_data), .read_len(read_len), .hold_active(hold_active),
    .timeout_flag(timeout_flag));

// ### verification/sph_client.sv
// Client model: sends link bytes and collects the sequencer's replies
`timescale 1ns/1ns
module sph_client (
    input  wire       clk_sys,
    input  wire       slow,
    input  wire [7:0] tx_data,
    input  wire       tx_valid,
    output reg  [7:0] rx_data,
    output reg        rx_valid,
    output reg        tx_ready
);
    reg [7:0] got [$];
    reg [1:0] cnt;
    initial begin
        rx_data  = 8'hA5;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
        cnt      = 2'h0;
    end
    // Slow mode takes one byte in four, so the reply path must stall
    always @(posedge clk_sys) begin
        if (tx_valid && tx_ready) got.push_back(tx_data);
        cnt      <= cnt + 2'h1;
        tx_ready <= !slow || cnt == 2'h0;
    end
    // Whole byte per call; the line shows the inverse between bytes, not a stale copy
    task send(input [7:0] b);
        begin
            @(posedge clk_sys);
            rx_data  <= b;
            rx_valid <= 1'b1;
            @(posedge clk_sys);
            rx_data  <= ~b;
            rx_valid <= 1'b0;
        end
    endtask
endmodule // sph_client

// ### verification/testbench.sv
// Self-checking bench for the packet handshake sequencer
`timescale 1ns/1ns
`include "sph_defs.vh"
module testbench;
    localparam TCYC = 200;
    reg         clk_sys, rst_b, exec_ok, exec_done, slow;
    reg  [2:0]  dly;
    reg  [63:0] read_data;
    reg  [7:0]  read_len;
    wire [7:0]  rx_data, tx_data, cmd_arg_len;
    wire        rx_valid, tx_valid, tx_ready, cmd_is_read, cmd_strobe, hold_active, timeout_flag;
    wire [31:0] cmd_word;
    wire [63:0] cmd_arg;
    integer     errors, samples_checked, seed, i, k;
    reg  [7:0]  body [$];
    reg  [7:0]  pkt [$];
    reg  [7:0]  ps_pkt [$];
    reg  [7:0]  dg [0:2];
    sph_seq #(.DATA_MAX(8), .TIMEOUT_CYC(TCYC)) i_sph_seq (.clk_sys(clk_sys), .rst_b(rst_b),
        .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .cmd_word(cmd_word), .cmd_arg(cmd_arg),
        .cmd_arg_len(cmd_arg_len), .cmd_is_read(cmd_is_read), .cmd_strobe(cmd_strobe),
        .exec_done(exec_done), .exec_ok(exec_ok), .read_data(read_data),
        .read_len(read_len), .hold_active(hold_active), .timeout_flag(timeout_flag));
    sph_client i_sph_client (.clk_sys(clk_sys), .slow(slow), .tx_data(tx_data),
        .tx_valid(tx_valid), .rx_data(rx_data), .rx_valid(rx_valid), .tx_ready(tx_ready));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Executor answers four cycles after each command strobe
    always @(posedge clk_sys) begin
        dly       <= {dly[1:0], cmd_strobe};
        exec_done <= dly[2];
    end
    task close_out;
        begin
            $display("TB: errors %0d samples_checked %0d", errors, samples_checked);
            if (errors == 0 && samples_checked > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    task check(input string name, input [63:0] seen, input [63:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("CHECK FAILED %0s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    function [7:0] hx(input [3:0] n);
        hx = (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
    endfunction
    // Frames the body: start, length, body, checksum of length..body, end
    task frame;
        reg [7:0] n, ck;
        begin
            n = body.size();
            pkt = {`SPH_STX, hx(n[7:4]), hx(n[3:0])};
            pkt = {pkt, body};
            ck = 8'h00;
            for (i = 1; i < pkt.size(); i++) ck = ck - pkt[i];
            pkt = {pkt, hx(ck[7:4]), hx(ck[3:0]), `SPH_ETX};
        end
    endtask
    task sendq;
        for (k = 0; k < pkt.size(); k++) i_sph_client.send(pkt[k]);
    endtask
    task expect_pkt(input string name);
        integer t;
        begin
            for (t = 0; t < 3000 && i_sph_client.got.size() < pkt.size(); t++) @(posedge clk_sys);
            if (t == 3000) begin
                errors = errors + 1;
                $display("CHECK FAILED %0s expected reply seen none", name);
                close_out;
            end else begin
                for (k = 0; k < pkt.size(); k++) check(name, i_sph_client.got[k], pkt[k]);
                repeat (4) @(posedge clk_sys);
                check("count", 64'(i_sph_client.got.size()), 64'(pkt.size()));
                i_sph_client.got.delete();
            end
        end
    endtask
    task reply(input [7:0] c);
        begin
            body = {`SPH_CHR_A, c};
            frame;
            expect_pkt("reply");
        end
    endtask
    task enq;
        begin
            i_sph_client.send(`SPH_ENQ);
            pkt = {`SPH_ACK};
            expect_pkt("ack");
        end
    endtask
    initial begin
        rst_b = 1'b0; exec_ok = 1'b1; exec_done = 1'b0; slow = 1'b0; dly = 3'h0;
        read_data = 64'h0; read_len = 8'h0; errors = 0; samples_checked = 0; seed = 4160;
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        enq;
        check("hold", hold_active, 64'h1);
        body = {8'h50, 8'h53, `SPH_SPACE, `SPH_SPACE, 8'h30, 8'h35, 8'h30, 8'h30};
        frame;
        ps_pkt = pkt;
        check("ck", {pkt[11], pkt[12]}, 64'h4630);
        sendq;
        reply(`SPH_CHR_0);
        check("word", cmd_word, 64'h50532020);
        check("arg", cmd_arg[63:32], 64'h30353030);
        check("alen", cmd_arg_len, 64'h4);
        check("rd", cmd_is_read, 64'h0);
        i_sph_client.send(`SPH_EOT);
        repeat (4) @(posedge clk_sys);
        check("idle", hold_active, 64'h0);
        $display("TB: write test done");
        slow <= 1'b1;
        exec_ok <= 1'b0;
        enq;
        pkt = ps_pkt;
        sendq;
        reply(`SPH_CHR_2);
        i_sph_client.send(`SPH_EOT);
        slow <= 1'b0;
        exec_ok <= 1'b1;
        enq;
        pkt = ps_pkt;
        pkt[12] = pkt[12] ^ 8'h01;
        sendq;
        reply(`SPH_CHR_2);
        $display("TB: failure tests done");
        for (k = 0; k < 3; k++) dg[k] = 8'h30 + 8'($unsigned($random(seed)) % 10);
        read_data <= {dg[0], dg[1], dg[2], 40'h0};
        read_len <= 8'h3;
        enq;
        body = {8'h55, 8'h41, `SPH_SPACE, `SPH_SPACE};
        frame;
        sendq;
        reply(`SPH_CHR_0);
        check("rd", cmd_is_read, 64'h1);
        i_sph_client.send(`SPH_ACK);
        body = {`SPH_CHR_D, `SPH_CHR_0, dg[0], dg[1], dg[2]};
        frame;
        expect_pkt("data");
        i_sph_client.send(`SPH_EOT);
        $display("TB: read test done");
        enq;
        repeat (150) @(posedge clk_sys);
        i_sph_client.send(8'h5A);
        repeat (150) @(posedge clk_sys);
        check("early", 64'(i_sph_client.got.size()), 64'h0);
        reply(`SPH_CHR_2);
        check("tflag", timeout_flag, 64'h1);
        enq;
        check("tclr", timeout_flag, 64'h0);
        $display("TB: timeout test done");
        close_out;
    end
endmodule // testbench
